// ### hdl/mts_trigger_seq.sv
`timescale 1ns/10ps
module mts_trigger_seq
   import mts_pkg::*;
(
   input wire logic i_clock, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic [MTS_CHAN_W-1:0] i_cfg_chan, // Channel to write
   input wire logic i_cfg_we, // Write settings of that channel
   input wire logic [MTS_LEVEL_W-1:0] i_cfg_level, // Trigger level
   input wire logic [MTS_LEVEL_W-1:0] i_cfg_hyst, // Hysteresis
   input wire logic signed [MTS_TIME_W-1:0] i_cfg_delay, // Delay, signed ticks
   input wire logic [MTS_TIME_W-1:0] i_cfg_holdoff, // Holdoff ticks
   input wire logic i_cfg_ext, // Source external
   input wire logic i_cfg_falling, // Falling slope
   input wire logic i_cfg_single, // Single-shot mode
   input wire logic i_cfg_realtime, // Realtime, chopper off in scope mode
   input wire logic i_cfg_gamma_en, // Correction enable
   input wire logic [MTS_GAMMA_W-1:0] i_cfg_gamma_mag, // Gamma magnitude
   input wire logic [MTS_GAMMA_W-1:0] i_cfg_gamma_phase, // Gamma phase
   input wire logic [MTS_CHAN_W-1:0] i_sel_chan, // Active channel
   input wire logic [1:0] i_mode, // Measurement mode
   input wire logic [MTS_LEVEL_W-1:0] i_signal_level, // Measured level
   input wire logic i_ext_trigger, // External trigger pin
   input wire logic i_manual_trigger_key, // Front-panel key pin
   output logic o_meas_start, // Start measurement pulse
   output logic o_pretrigger, // Pre-trigger capture active
   output logic o_running, // Continuous running
   output logic o_armed, // Single shot armed
   output logic o_holdoff, // Holdoff active
   output logic o_chopper_en, // Chopper enabled
   output logic o_gamma_en, // Correction active
   output logic [MTS_GAMMA_W-1:0] o_gamma_mag, // Correction magnitude
   output logic [MTS_GAMMA_W-1:0] o_gamma_phase // Correction phase
);
   // Per-channel settings banks
   logic [MTS_LEVEL_W-1:0] level_ff [MTS_CHANNELS];
   logic [MTS_LEVEL_W-1:0] hyst_ff [MTS_CHANNELS];
   logic [MTS_TIME_W-1:0] delay_ff [MTS_CHANNELS];
   logic [MTS_TIME_W-1:0] holdoff_ff [MTS_CHANNELS];
   logic [MTS_CHANNELS-1:0] ext_ff, fall_ff, single_ff, rt_ff, gen_ff;
   logic [MTS_GAMMA_W-1:0] gmag_ff [MTS_CHANNELS];
   logic [MTS_GAMMA_W-1:0] gph_ff [MTS_CHANNELS];

   // Settings write, one channel at a time
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int i = 0; i < MTS_CHANNELS; i++) begin
            level_ff[i] <= MTS_LEVEL_RST;
            hyst_ff[i] <= MTS_LEVEL_RST;
            delay_ff[i] <= MTS_TIME_RST;
            holdoff_ff[i] <= MTS_TIME_RST;
            gmag_ff[i] <= '0;
            gph_ff[i] <= '0;
         end
         ext_ff <= '0;
         fall_ff <= '0;
         single_ff <= '0;
         rt_ff <= '0;
         gen_ff <= '0;
      end else if (i_cfg_we) begin
         level_ff[i_cfg_chan] <= i_cfg_level;
         hyst_ff[i_cfg_chan] <= i_cfg_hyst;
         delay_ff[i_cfg_chan] <= i_cfg_delay;
         holdoff_ff[i_cfg_chan] <= i_cfg_holdoff;
         ext_ff[i_cfg_chan] <= i_cfg_ext;
         fall_ff[i_cfg_chan] <= i_cfg_falling;
         single_ff[i_cfg_chan] <= i_cfg_single;
         rt_ff[i_cfg_chan] <= i_cfg_realtime;
         gen_ff[i_cfg_chan] <= i_cfg_gamma_en;
         gmag_ff[i_cfg_chan] <= i_cfg_gamma_mag;
         gph_ff[i_cfg_chan] <= i_cfg_gamma_phase;
      end
   end

   // Active channel selection
   wire [MTS_LEVEL_W-1:0] lvl = level_ff[i_sel_chan];
   wire [MTS_LEVEL_W-1:0] hys = hyst_ff[i_sel_chan];
   wire [MTS_TIME_W-1:0] dly = delay_ff[i_sel_chan];
   wire s_ext = ext_ff[i_sel_chan];
   wire s_fall = fall_ff[i_sel_chan];
   wire s_single = single_ff[i_sel_chan];
   wire dly_neg = dly[MTS_TIME_W-1];
   wire [MTS_TIME_W-1:0] dly_pos = dly_neg ? '0 : dly;

   // Pin synchronisers
   logic ext_s1_ff, ext_s2_ff, ext_d_ff, key_s1_ff, key_s2_ff, key_d_ff;
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_d_ff <= 1'b0;
         key_s1_ff <= 1'b0;
         key_s2_ff <= 1'b0;
         key_d_ff <= 1'b0;
      end else begin
         ext_s1_ff <= i_ext_trigger;
         ext_s2_ff <= ext_s1_ff;
         ext_d_ff <= ext_s2_ff;
         key_s1_ff <= i_manual_trigger_key;
         key_s2_ff <= key_s1_ff;
         key_d_ff <= key_s2_ff;
      end
   end
   wire key_press = key_s2_ff && !key_d_ff;

   // Level crossing with hysteresis re-arm
   wire [MTS_LEVEL_W:0] lvl_lo = {1'b0, lvl} - {1'b0, hys};
   wire [MTS_LEVEL_W:0] lvl_hi = {1'b0, lvl} + {1'b0, hys};
   wire [MTS_LEVEL_W:0] sig_x = {1'b0, i_signal_level};
   wire above = i_signal_level > lvl;
   wire below = i_signal_level < lvl;
   wire past_hyst = s_fall ? (sig_x > lvl_hi) : (lvl_lo[MTS_LEVEL_W] ? 1'b0 : sig_x < lvl_lo);
   logic rearm_ff;
   wire int_event = rearm_ff && (s_fall ? below : above);
   wire ext_event = s_fall ? (!ext_s2_ff && ext_d_ff) : (ext_s2_ff && !ext_d_ff);
   wire raw_event = s_ext ? ext_event : int_event;
   wire trig_mode = (i_mode != MTS_MODE_CONT_AVG);

   // Timers
   logic tick, hold_busy, dly_busy, dly_pend_ff;
   mts_tick u_tick (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .o_tick(tick)
   );

   // Sequencer state
   logic run_ff, arm_ff;
   wire scope = (i_mode == MTS_MODE_SCOPE);
   wire force_trig = s_single && arm_ff && key_press;
   wire gate_ok = s_single ? arm_ff : run_ff;
   wire accept = trig_mode && !dly_pend_ff &&
                 ((raw_event && !hold_busy && gate_ok) || force_trig);
   wire dly_done = dly_pend_ff && !dly_busy;

   mts_timer u_hold (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_load(accept),
      .i_value(holdoff_ff[i_sel_chan]),
      .i_tick(tick),
      .o_busy(hold_busy)
   );
   mts_timer u_dly (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_load(accept),
      .i_value(dly_pos),
      .i_tick(tick),
      .o_busy(dly_busy)
   );

   // Hysteresis re-arm flag
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rearm_ff <= 1'b1;
      end else if (accept || (int_event && !s_ext)) begin
         rearm_ff <= past_hyst;
      end else if (past_hyst) begin
         rearm_ff <= 1'b1;
      end
   end

   // Run/stop, arming and delay tracking
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         run_ff <= 1'b1;
         arm_ff <= 1'b0;
         dly_pend_ff <= 1'b0;
      end else begin
         if (!s_single && scope && key_press) begin
            run_ff <= !run_ff;
         end
         if (accept) begin
            arm_ff <= 1'b0;
         end else if (s_single && !arm_ff && key_press) begin
            arm_ff <= 1'b1;
         end
         if (accept) begin
            dly_pend_ff <= 1'b1;
         end else if (dly_done) begin
            dly_pend_ff <= 1'b0;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_meas_start <= 1'b0;
         o_pretrigger <= 1'b0;
         o_running <= 1'b0;
         o_armed <= 1'b0;
         o_holdoff <= 1'b0;
         o_chopper_en <= 1'b1;
         o_gamma_en <= 1'b0;
         o_gamma_mag <= '0;
         o_gamma_phase <= '0;
      end else begin
         o_meas_start <= dly_done;
         o_pretrigger <= trig_mode && dly_neg;
         o_running <= run_ff && !s_single;
         o_armed <= arm_ff;
         o_holdoff <= hold_busy;
         o_chopper_en <= !(rt_ff[i_sel_chan] && scope);
         o_gamma_en <= gen_ff[i_sel_chan];
         o_gamma_mag <= gen_ff[i_sel_chan] ? gmag_ff[i_sel_chan] : '0;
         o_gamma_phase <= gen_ff[i_sel_chan] ? gph_ff[i_sel_chan] : '0;
      end
   end

   // Assertions
   sequence s_accept_seq;
      accept;
   endsequence
   chk_start_after_accept: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_accept_seq |=> !o_meas_start)
      else $error("start in accept cycle");
   chk_holdoff_blocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (hold_busy && !force_trig) |-> !accept)
      else $error("event accepted during holdoff");
   chk_single_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (s_single && !arm_ff) |-> !accept)
      else $error("single accepted while unarmed");
   chk_arm_clears: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (accept && s_single) |=> !arm_ff)
      else $error("arm not cleared");
   chk_force_accepts: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (force_trig && trig_mode && !dly_pend_ff) |-> accept)
      else $error("force trigger ignored");
   chk_run_toggle: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!s_single && scope && key_press) |=> (run_ff != $past(run_ff)))
      else $error("run not toggled");
   chk_avg_no_trig: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_mode == MTS_MODE_CONT_AVG) |-> !accept)
      else $error("trigger in average mode");
   chk_zero_delay: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (accept && dly_pos == '0) |-> ##2 o_meas_start)
      else $error("zero delay start late");
   chk_hold_load: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (accept && holdoff_ff[i_sel_chan] != '0) |=> hold_busy)
      else $error("holdoff not loaded");

   // Pending delay keeps further events out until the start
   sequence s_delay_wait_seq;
      dly_pend_ff && dly_busy;
   endsequence
   chk_delay_blocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_delay_wait_seq |-> !accept)
      else $error("event accepted while delay pending");
   chk_start_on_done: assert property (@(posedge i_clock) disable iff (!i_resetn)
      dly_done |=> o_meas_start)
      else $error("start missing after delay");
   chk_start_single: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_meas_start |=> !o_meas_start)
      else $error("start longer than one cycle");
   chk_delay_load: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (accept && dly_pos != '0) |=> dly_busy)
      else $error("delay not loaded");

   // Stopped run or missing re-arm drops events
   chk_stop_blocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!s_single && !run_ff) |-> !accept)
      else $error("event accepted while stopped");
   chk_rearm_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!s_ext && !rearm_ff && !force_trig) |-> !accept)
      else $error("internal event before re-arm");

   // Qualified crossings and pin edges reach the accept decision
   sequence s_int_ready_seq;
      trig_mode && !s_ext && rearm_ff && !hold_busy && !dly_pend_ff && gate_ok;
   endsequence
   chk_rise_accepts: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_int_ready_seq ##0 (!s_fall && above) |-> accept)
      else $error("rising crossing not accepted");
   chk_fall_accepts: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_int_ready_seq ##0 (s_fall && below) |-> accept)
      else $error("falling crossing not accepted");
   chk_ext_accepts: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (trig_mode && s_ext && ext_event && !hold_busy && !dly_pend_ff && gate_ok)
      |-> accept)
      else $error("external edge not accepted");

   // Key press arms a single shot
   sequence s_arm_press_seq;
      s_single && !arm_ff && key_press;
   endsequence
   chk_key_arms: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_arm_press_seq |=> arm_ff)
      else $error("key press did not arm");

   // Status and correction outputs follow the active channel
   chk_pretrig_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (trig_mode && dly_neg) |=> o_pretrigger)
      else $error("pre-trigger flag missing");
   chk_chopper_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (rt_ff[i_sel_chan] && scope) |=> !o_chopper_en)
      else $error("chopper left on in realtime scope");
   chk_gamma_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !gen_ff[i_sel_chan] |=> (!o_gamma_en && o_gamma_mag == '0 && o_gamma_phase == '0))
      else $error("correction shown while disabled");
endmodule

// ### hdl/mts_pkg.sv
package mts_pkg;
   // Channel count and selector width
   localparam int MTS_CHANNELS = 4;
   localparam int MTS_CHAN_W = 2;
   // Level, time and correction widths
   localparam int MTS_LEVEL_W = 16;
   localparam int MTS_TIME_W = 24;
   localparam int MTS_GAMMA_W = 16;
   // Clock rate and time base of programmed times (1 us per count)
   localparam int MTS_CLOCK_HZ = 10000000;
   localparam int MTS_TICK_NS = 1000;
   localparam int MTS_CLOCK_NS = 1000000000 / MTS_CLOCK_HZ;
   localparam int MTS_TICK_CYCLES = (MTS_TICK_NS + MTS_CLOCK_NS - 1) / MTS_CLOCK_NS;
   // Measurement modes
   typedef enum logic [1:0] {
      MTS_MODE_CONT_AVG = 2'h0,
      MTS_MODE_BURST = 2'h1,
      MTS_MODE_TIMESLOT = 2'h2,
      MTS_MODE_SCOPE = 2'h3
   } mts_mode_t;
   // Reset values of per-channel settings
   localparam logic [MTS_LEVEL_W-1:0] MTS_LEVEL_RST = 16'h0000;
   localparam logic [MTS_TIME_W-1:0] MTS_TIME_RST = 24'h000000;
endpackage

// ### hdl/mts_tick.sv
`timescale 1ns/10ps
// Divider giving one-cycle enable pulses at the time-base rate
module mts_tick
   import mts_pkg::*;
#(
   parameter int DIV = MTS_TICK_CYCLES
) (
   input wire logic i_clock, // System clock
   input wire logic i_resetn, // Async reset, active low
   output logic o_tick // Time-base enable pulse
);
   logic [15:0] cnt_ff;
   wire wrap = (cnt_ff == 16'(DIV - 1));

   // Free-running divide counter
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_ff <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_ff <= wrap ? 16'h0000 : cnt_ff + 16'h0001;
         o_tick <= wrap;
      end
   end
endmodule

// ### hdl/mts_timer.sv
`timescale 1ns/10ps
// Loadable down counter on the time-base enable
module mts_timer
   import mts_pkg::*;
#(
   parameter int W = MTS_TIME_W
) (
   input wire logic i_clock, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic i_load, // Load programmed time
   input wire logic [W-1:0] i_value, // Programmed time in ticks
   input wire logic i_tick, // Time-base enable
   output logic o_busy // Counting, not yet expired
);
   logic [W-1:0] cnt_ff;

   // Load or count down once per tick
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_ff <= '0;
      end else if (i_load) begin
         cnt_ff <= i_value;
      end else if (i_tick && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end
   assign o_busy = (cnt_ff != '0);
endmodule

// ### verif/mts_panel_model.sv
`timescale 1ns/10ps
// Operator key and external trigger source
module mts_panel_model (
   input wire logic i_clock, // System clock
   output logic o_ext_trigger, // External trigger pin
   output logic o_key // Front-panel key pin
);
   // Both pins idle low
   initial begin
      o_ext_trigger = 1'b0;
      o_key = 1'b0;
   end
   // Key held four cycles, then released four
   task automatic press();
      @(posedge i_clock);
      o_key <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_key <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask
   // One rising pulse on the external pin
   task automatic pulse();
      @(posedge i_clock);
      o_ext_trigger <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_ext_trigger <= 1'b0;
   endtask
endmodule

// ### verif/mts_trigger_seq_tb.sv
`timescale 1ns/10ps
// Bench for the trigger sequencer
module mts_trigger_seq_tb;
   import mts_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] c_chan = 2'h0;
   logic [1:0] sel = 2'h0;
   logic [1:0] mode = 2'h0;
   logic we = 1'b0;
   logic ext = 1'b0;
   logic fall = 1'b0;
   logic single = 1'b0;
   logic rt = 1'b0;
   logic gen = 1'b0;
   logic [15:0] level = 16'h0064;
   logic [15:0] hyst = 16'h000a;
   logic [15:0] mag = 16'h0000;
   logic [15:0] ph = 16'h0000;
   logic [15:0] sig = 16'h0000;
   logic signed [23:0] dly = 24'h000000;
   logic [23:0] hold = 24'h000005;
   wire start, pre, running, armed, hoff, chop, gen_o, ext_pin, key_pin;
   wire [15:0] mag_o, ph_o;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int cnt;
   int m;
   mts_trigger_seq mts_trigger_seq_i (.i_clock(clock), .i_resetn(resetn),
      .i_cfg_chan(c_chan), .i_cfg_we(we), .i_cfg_level(level), .i_cfg_hyst(hyst),
      .i_cfg_delay(dly), .i_cfg_holdoff(hold), .i_cfg_ext(ext), .i_cfg_falling(fall),
      .i_cfg_single(single), .i_cfg_realtime(rt), .i_cfg_gamma_en(gen),
      .i_cfg_gamma_mag(mag), .i_cfg_gamma_phase(ph), .i_sel_chan(sel), .i_mode(mode),
      .i_signal_level(sig), .i_ext_trigger(ext_pin), .i_manual_trigger_key(key_pin),
      .o_meas_start(start), .o_pretrigger(pre), .o_running(running), .o_armed(armed),
      .o_holdoff(hoff), .o_chopper_en(chop), .o_gamma_en(gen_o), .o_gamma_mag(mag_o),
      .o_gamma_phase(ph_o));
   mts_panel_model panel_i (.i_clock(clock), .o_ext_trigger(ext_pin), .o_key(key_pin));
   // Clock and hang guard
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         stop_test();
      end
   end
   // Verdict and end of run
   task stop_test();
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Compare seen against expected
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Drive a level, count start pulses over n cycles
   task t(input int n, input logic [15:0] s, input int exp);
      cnt = 0;
      @(posedge clock);
      sig <= s;
      repeat (n) begin
         @(negedge clock);
         if (start === 1'b1) cnt++;
      end
      chk(cnt, exp);
   endtask
   // Write one channel: flags ext, fall, single, realtime, gamma
   task wr(input logic [1:0] ch, input logic [4:0] b, input logic signed [23:0] d,
      input logic [15:0] g);
      @(posedge clock);
      c_chan <= ch;
      {ext, fall, single, rt, gen} <= b;
      dly <= d;
      mag <= g;
      ph <= g ^ 16'h00ff;
      we <= 1'b1;
      @(posedge clock);
      we <= 1'b0;
   endtask
   // Select channel and mode
   task sm(input logic [1:0] ch, input logic [1:0] md);
      @(posedge clock);
      sel <= ch;
      mode <= md;
   endtask
   // Main sequence
   initial begin
      repeat (19) @(posedge clock);
      chk({start, pre, running, armed, hoff, chop, gen_o}, 7'h02);
      @(posedge clock);
      resetn <= 1'b1;
      wr(2'h0, 5'h00, 24'sd0, 16'h0000);
      wr(2'h1, 5'h08, 24'sd0, 16'h0000);
      wr(2'h2, 5'h11, 24'sd0, 16'h1234);
      wr(2'h3, 5'h00, 24'sd3, 16'habcd);
      for (m = 0; m < 4; m++) begin
         sm(2'h0, m[1:0]);
         t(70, 16'h0032, 0);
         t(6, 16'h0096, int'(m != 0));
      end
      t(70, 16'h0096, 0);
      chk(hoff, 1'b0);
      t(3, 16'h005f, 0);
      t(5, 16'h0096, 0);
      t(3, 16'h0050, 0);
      t(6, 16'h0096, 1);
      chk(hoff, 1'b1);
      t(3, 16'h0032, 0);
      t(5, 16'h0096, 0);
      t(70, 16'h0032, 0);
      t(6, 16'h0096, 1);
      sm(2'h1, 2'h1);
      t(70, 16'h0096, 0);
      t(6, 16'h0032, 1);
      sm(2'h2, 2'h2);
      t(70, 16'h0032, 0);
      t(6, 16'h0096, 0);
      chk({gen_o, mag_o, ph_o}, {1'b1, 16'h1234, 16'h12cb});
      fork
         panel_i.pulse();
         t(14, 16'h0096, 1);
      join
      // External source on the falling pin edge
      wr(2'h2, 5'h19, 24'sd0, 16'h1234);
      t(70, 16'h0096, 0);
      fork
         panel_i.pulse();
         t(14, 16'h0096, 1);
      join
      sm(2'h3, 2'h1);
      t(70, 16'h0032, 0);
      chk({gen_o, mag_o, ph_o}, 33'h0);
      // Three ticks of delay: start lands 23 to 32 cycles after the crossing
      t(22, 16'h0096, 0);
      t(33, 16'h0096, 1);
      wr(2'h3, 5'h00, -24'sd2, 16'h0000);
      t(3, 16'h0032, 0);
      chk(pre, 1'b1);
      wr(2'h0, 5'h04, 24'sd0, 16'h0000);
      sm(2'h0, 2'h3);
      t(70, 16'h0032, 0);
      t(6, 16'h0096, 0);
      chk({chop, running, armed}, 3'h4);
      t(3, 16'h0032, 0);
      panel_i.press();
      @(negedge clock);
      chk(armed, 1'b1);
      t(6, 16'h0096, 1);
      chk(armed, 1'b0);
      t(70, 16'h0032, 0);
      t(6, 16'h0096, 0);
      t(70, 16'h0032, 0);
      panel_i.press();
      fork
         panel_i.press();
         t(14, 16'h0032, 1);
      join
      wr(2'h0, 5'h02, 24'sd0, 16'h0000);
      t(70, 16'h0032, 0);
      chk({chop, running}, 2'h1);
      panel_i.press();
      @(negedge clock);
      chk(running, 1'b0);
      t(6, 16'h0096, 0);
      panel_i.press();
      @(negedge clock);
      chk(running, 1'b1);
      sm(2'h0, 2'h1);
      t(3, 16'h0032, 0);
      chk(chop, 1'b1);
      stop_test();
   end
endmodule
